// ---- verilog/analog_mix_route_regs.sv ----
// Avalon-MM register bank for analog routing and volume controls
`timescale 1ns/10ps
`default_nettype none
module analog_mix_route_regs
(
   input wire logic ref_clk_i,                   // 100 MHz clock
   input wire logic rst_i,                       // Async reset, high
   input wire logic power_down_pin_n_i,          // Power-down pin, low
   input wire logic [6:0] avs_address_i,         // Byte address bits 6:0
   input wire logic avs_read_i,                  // Read request
   input wire logic avs_write_i,                 // Write request
   input wire logic [31:0] avs_writedata_i,      // Write data
   input wire logic [3:0] avs_byteenable_i,      // Byte enables
   output logic [31:0] avs_readdata_o,           // Read data
   output logic avs_waitrequest_o,               // Wait request
   output mix_route_pkg::analog_ctrl_type ctrl_o // Analog controls
);
   import mix_route_pkg::*;

   // Pin synchroniser and bus state
   logic pdn_meta_r;           // First stage, read only by second
   logic pdn_sync_n_r;         // Synchronised pin, low = power down
   logic ack_r;                // Access answered this cycle
   logic [31:0] rdata_r;       // Registered read data
   // Registers
   logic [7:0] lineout_route_a_r;
   logic [7:0] lineout_volume_r;
   logic [7:0] headphone_route_b_r;
   logic [7:0] headphone_volume_r;
   logic [7:0] lineout_route_b_r;
   logic [7:0] mono_average_route_r;
   logic [7:0] differential_select_r;
   logic [7:0] lineout_mute_r;
   // Decode
   logic [4:0] idx;            // Word index
   logic wr_go;                // Write commits this cycle
   logic [7:0] wbyte;          // Low byte of write data
   analog_ctrl_type ctrl_nxt;  // Next analog controls

   // Read mux of one register index, reserved bits zero
   function automatic logic [7:0] reg_value(input logic [4:0] i);
      logic [7:0] v;
      v = 8'h00;
      case (i)
         IDX_LINEOUT_ROUTE_A: v = lineout_route_a_r;
         IDX_LINEOUT_VOLUME: v = lineout_volume_r;
         IDX_HEADPHONE_ROUTE_B: v = headphone_route_b_r;
         IDX_HEADPHONE_VOLUME: v = headphone_volume_r;
         IDX_LINEOUT_ROUTE_B: v = lineout_route_b_r;
         IDX_MONO_AVERAGE_ROUTE: v = mono_average_route_r;
         IDX_DIFFERENTIAL_SELECT: v = differential_select_r;
         IDX_LINEOUT_MUTE_CTRL: v = lineout_mute_r;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : reg_value

   // Register update: masked write, or defaults while powered down
   function automatic logic [7:0] reg_next(input logic [7:0] cur,
      input logic [4:0] me, input logic [7:0] mask,
      input logic [7:0] dflt);
      logic [7:0] n;
      n = cur;
      if (!pdn_sync_n_r)
      begin
         n = dflt; // RL16
      end
      else if (wr_go && (idx == me))
      begin
         n = wbyte & mask; // RL3
      end
      return n;
   endfunction : reg_next

   assign idx = avs_address_i[6:2];
   assign wbyte = avs_writedata_i[7:0];
   // Write takes effect only on the answering edge, lane 0 enabled
   assign wr_go = avs_write_i && ack_r && avs_byteenable_i[0]; // RL19
   // One wait cycle, then answer
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign avs_readdata_o = rdata_r;

   // Two-flop synchroniser for the power-down pin
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pdn_meta_r <= 1'b0;
         pdn_sync_n_r <= 1'b0;
      end
      else
      begin
         pdn_meta_r <= power_down_pin_n_i;
         pdn_sync_n_r <= pdn_meta_r;
      end
   end

   // Bus answer and read data capture
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         rdata_r <= READ_UNMAPPED;
      end
      else
      begin
         // Ack pulses one cycle after request seen
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
         if (avs_read_i && !ack_r)
         begin
            rdata_r <= {24'h000000, reg_value(idx)}; // RL19
         end
      end
   end

   // Register file
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lineout_route_a_r <= RST_ZERO;      // RL1
         lineout_volume_r <= RST_ZERO;       // RL4
         headphone_route_b_r <= RST_ZERO;    // RL6
         headphone_volume_r <= RST_ZERO;     // RL7
         lineout_route_b_r <= RST_ZERO;      // RL11
         mono_average_route_r <= RST_ZERO;   // RL12
         differential_select_r <= RST_ZERO;  // RL13
         lineout_mute_r <= RST_LINEOUT_MUTE; // RL17
      end
      else
      begin
         lineout_route_a_r <= reg_next(lineout_route_a_r,
            IDX_LINEOUT_ROUTE_A, MASK_LINEOUT_ROUTE_A, RST_ZERO);
         lineout_volume_r <= reg_next(lineout_volume_r,
            IDX_LINEOUT_VOLUME, MASK_LINEOUT_VOLUME, RST_ZERO);
         headphone_route_b_r <= reg_next(headphone_route_b_r,
            IDX_HEADPHONE_ROUTE_B, MASK_ROUTE_B, RST_ZERO);
         headphone_volume_r <= reg_next(headphone_volume_r,
            IDX_HEADPHONE_VOLUME, MASK_HEADPHONE_VOLUME, RST_ZERO);
         lineout_route_b_r <= reg_next(lineout_route_b_r,
            IDX_LINEOUT_ROUTE_B, MASK_ROUTE_B, RST_ZERO);
         mono_average_route_r <= reg_next(mono_average_route_r,
            IDX_MONO_AVERAGE_ROUTE, MASK_MONO_AVERAGE, RST_ZERO);
         differential_select_r <= reg_next(differential_select_r,
            IDX_DIFFERENTIAL_SELECT, MASK_DIFFERENTIAL, RST_ZERO);
         lineout_mute_r <= reg_next(lineout_mute_r,
            IDX_LINEOUT_MUTE_CTRL, MASK_LINEOUT_MUTE, RST_LINEOUT_MUTE);
      end
   end

   // Effective analog controls from the registers
   always_comb
   begin
      ctrl_nxt = '0;
      ctrl_nxt.lineout_route_a = lineout_route_a_r[6:0]; // RL1
      ctrl_nxt.lineout_gain_6db = lineout_route_a_r[POS_GAIN]; // RL2
      ctrl_nxt.lineout_silence = lineout_mute_r[0]; // RL17
      // Volume forced to zero while muted
      ctrl_nxt.lineout_volume_field = lineout_mute_r[0] ? 4'h0 :
         lineout_volume_r[3:0]; // RL5
      ctrl_nxt.headphone_silence = headphone_volume_r[POS_HP_MUTE]; // RL9
      ctrl_nxt.headphone_volume_field =
         headphone_volume_r[POS_HP_MUTE] ? 5'h00 :
         headphone_volume_r[4:0]; // RL8
      ctrl_nxt.headphone_pulldown_select =
         headphone_volume_r[POS_HP_PULLDOWN]; // RL10
      ctrl_nxt.headphone_route_b = headphone_route_b_r; // RL6
      ctrl_nxt.lineout_route_b = lineout_route_b_r; // RL11
      ctrl_nxt.pair_avg_route = mono_average_route_r[5:0]; // RL12
      ctrl_nxt.differential_enable =
         differential_select_r[POS_DIFF_EN]; // RL13
      ctrl_nxt.differential_to_headphone =
         differential_select_r[POS_DIFF_EN] &&
         differential_select_r[POS_DIFF_HP]; // RL14
      ctrl_nxt.differential_to_mono =
         differential_select_r[POS_DIFF_EN] &&
         differential_select_r[POS_DIFF_MONO]; // RL15
   end

   // Registered analog outputs, updated after the write edge
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_o <= '0;
         ctrl_o.lineout_silence <= 1'b1; // RL4
      end
      else
      begin
         ctrl_o <= ctrl_nxt; // RL19
      end
   end

   // Synchronised power-down forces defaults one cycle later
   AST_PDN_DEFAULTS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!pdn_sync_n_r) |=> (lineout_volume_r == 8'h00 &&
      lineout_mute_r == 8'h01 && differential_select_r == 8'h00))
      else $error("power down did not force defaults"); // RL16
   AST_LO_MUTE_VOL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ctrl_o.lineout_silence |-> ctrl_o.lineout_volume_field == 4'h0)
      else $error("lineout volume leaks while muted"); // RL5
   AST_LO_VOL_FOLLOW: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (!lineout_mute_r[0]) |=> ctrl_o.lineout_volume_field ==
      $past(lineout_volume_r[3:0]))
      else $error("lineout volume not applied"); // RL5
   AST_HP_MUTE_VOL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ctrl_o.headphone_silence |-> ctrl_o.headphone_volume_field == 5'h00)
      else $error("headphone attenuation used while muted"); // RL9
   AST_DIFF_HP_GATE: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      ctrl_o.differential_to_headphone |-> ctrl_o.differential_enable)
      else $error("diff to headphone without enable"); // RL14
   AST_DIFF_MONO_GATE: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (differential_select_r[2:0] == 3'b101) |=>
      ctrl_o.differential_to_mono)
      else $error("diff to mono not applied"); // RL15
   AST_VOL_RESERVED: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      lineout_volume_r[7:4] == 4'h0 && mono_average_route_r[7:6] == 2'b00)
      else $error("reserved bits set"); // RL3
   AST_WRITE_COMMIT: assert property (@(posedge ref_clk_i)
      disable iff (rst_i)
      (wr_go && idx == IDX_LINEOUT_ROUTE_B && pdn_sync_n_r) |=>
      lineout_route_b_r == $past(wbyte) ##1
      ctrl_o.lineout_route_b == $past(lineout_route_b_r))
      else $error("lineout route write not committed"); // RL11
   AST_GAIN_OUT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ##1 ctrl_o.lineout_gain_6db == $past(lineout_route_a_r[6]))
      else $error("gain bit not driven"); // RL2
   AST_WAIT_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($rose(avs_read_i) && !ack_r) |-> avs_waitrequest_o ##1
      !avs_waitrequest_o)
      else $error("answer not after one wait cycle"); // RL19
endmodule : analog_mix_route_regs
`default_nettype wire

// ---- verilog/mix_route_pkg.sv ----
// Constants, register map and carrier types of the analog mix route bank
// Contract
// [RL1] Lineout select bits each add one source
// [RL2] Gain bit: 0 gives 0dB, 1 gives +6dB
// [RL3] Lineout volume low nibble, upper bits zero
// [RL4] Reset: volume 0000, lineout mute set
// [RL5] Lineout volume applies only while unmuted
// [RL6] Eight headphone route bits, reset off
// [RL7] Headphone attenuation 00H, mute 0 at reset
// [RL8] Headphone attenuation applies only while unmuted
// [RL9] Headphone mute silences, ignores attenuation
// [RL10] Pull-down bit: 0 short, 1 weak resistor
// [RL11] Eight lineout route bits, reset off
// [RL12] Six pair-average route bits, reset zero
// [RL13] Differential enable makes pair, routes lineout
// [RL14] Differential to headphone needs enable
// [RL15] Differential to mono needs enable
// [RL16] Power-down low: writes ignored, defaults forced
// [RL17] Lineout mute resets to 1, mutes
// [RL18] Host writes zero to unused bits only
// [RL19] Outputs update after write completes; reserved zero
package mix_route_pkg;
   // Register word offsets (index); byte address is four times
   localparam logic [4:0] IDX_LINEOUT_ROUTE_A = 5'h08;
   localparam logic [4:0] IDX_LINEOUT_VOLUME = 5'h09;
   localparam logic [4:0] IDX_HEADPHONE_ROUTE_B = 5'h0d;
   localparam logic [4:0] IDX_HEADPHONE_VOLUME = 5'h0e;
   localparam logic [4:0] IDX_LINEOUT_ROUTE_B = 5'h0f;
   localparam logic [4:0] IDX_MONO_AVERAGE_ROUTE = 5'h10;
   localparam logic [4:0] IDX_DIFFERENTIAL_SELECT = 5'h11;
   localparam logic [4:0] IDX_LINEOUT_MUTE_CTRL = 5'h14;
   // Writable bit masks
   localparam logic [7:0] MASK_LINEOUT_ROUTE_A = 8'h7f;
   localparam logic [7:0] MASK_LINEOUT_VOLUME = 8'h0f;
   localparam logic [7:0] MASK_ROUTE_B = 8'hff;
   localparam logic [7:0] MASK_HEADPHONE_VOLUME = 8'h7f;
   localparam logic [7:0] MASK_MONO_AVERAGE = 8'h3f;
   localparam logic [7:0] MASK_DIFFERENTIAL = 8'h07;
   localparam logic [7:0] MASK_LINEOUT_MUTE = 8'h01;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_LINEOUT_MUTE = 8'h01;
   // Field positions
   localparam int POS_GAIN = 6;
   localparam int POS_HP_MUTE = 5;
   localparam int POS_HP_PULLDOWN = 6;
   localparam int POS_DIFF_EN = 0;
   localparam int POS_DIFF_HP = 1;
   localparam int POS_DIFF_MONO = 2;
   // Unmapped read answer
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // Analog control bundle driven to the switch and volume cells
   typedef struct packed {
      logic [6:0] lineout_route_a;      // DAC and line sources to lineout
      logic lineout_gain_6db;           // DAC to lineout +6dB
      logic [3:0] lineout_volume_field; // Effective lineout volume
      logic lineout_silence;            // Lineout muted
      logic [7:0] headphone_route_b;    // Extra headphone routes
      logic [4:0] headphone_volume_field; // Effective headphone volume
      logic headphone_silence;          // Headphone muted
      logic headphone_pulldown_select;  // 1 weak pull-down, 0 short
      logic [7:0] lineout_route_b;      // Extra lineout routes
      logic [5:0] pair_avg_route;       // (L+R)/2 routes
      logic differential_enable;        // Pair is differential, to lineout
      logic differential_to_headphone;  // Pair to headphone
      logic differential_to_mono;       // Pair to mono
   } analog_ctrl_type;
endpackage : mix_route_pkg

// ---- verification/testbench.sv ----
// Self-checking testbench for the analog mix route register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import mix_route_pkg::*;
   logic ref_clk_i = 1'b0; // Bench clock
   logic rst_i = 1'b1; // Reset, high
   logic pd_n = 1'b1; // Power-down pin
   logic [6:0] addr = 7'h00; // Byte address
   logic rd = 1'b0; // Read request
   logic wr = 1'b0; // Write request
   logic [31:0] wdata = 32'h0000_0000; // Write data
   logic [3:0] be = 4'h0; // Byte enables
   logic [31:0] rdata; // Read data
   logic wait_req; // Wait request
   analog_ctrl_type ctrl; // Analog controls
   logic [31:0] exp_q [$]; // Expected read data
   int miscompares = 0; // Mismatches
   int num_checks = 0; // Comparisons
   int seed = 42360; // Random seed
   logic [7:0] regv [8]; // Expected register contents
   logic [4:0] idx_tab [8] = '{IDX_LINEOUT_ROUTE_A, IDX_LINEOUT_VOLUME,
      IDX_HEADPHONE_ROUTE_B, IDX_HEADPHONE_VOLUME, IDX_LINEOUT_ROUTE_B,
      IDX_MONO_AVERAGE_ROUTE, IDX_DIFFERENTIAL_SELECT, IDX_LINEOUT_MUTE_CTRL};
   logic [7:0] mask_tab [8] = '{MASK_LINEOUT_ROUTE_A, MASK_LINEOUT_VOLUME,
      MASK_ROUTE_B, MASK_HEADPHONE_VOLUME, MASK_ROUTE_B, MASK_MONO_AVERAGE,
      MASK_DIFFERENTIAL, MASK_LINEOUT_MUTE};

   analog_mix_route_regs dut
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .power_down_pin_n_i(pd_n),
      .avs_address_i(addr),
      .avs_read_i(rd),
      .avs_write_i(wr),
      .avs_writedata_i(wdata),
      .avs_byteenable_i(be),
      .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_req),
      .ctrl_o(ctrl)
   );

   // Free-running 100 MHz clock
   always #5 ref_clk_i = ~ref_clk_i;

   // Compare and count
   task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   // Default register contents
   task automatic defaults;
      foreach (regv[k])
         regv[k] = (k == 7) ? RST_LINEOUT_MUTE : RST_ZERO;
   endtask : defaults

   // Expected control bundle, lineout route a left out
   function automatic analog_ctrl_type model();
      analog_ctrl_type e;
      e = '0;
      e.lineout_gain_6db = regv[0][POS_GAIN];
      e.lineout_silence = regv[7][0];
      e.lineout_volume_field = regv[7][0] ? 4'h0 : regv[1][3:0];
      e.headphone_route_b = regv[2];
      e.headphone_silence = regv[3][POS_HP_MUTE];
      e.headphone_volume_field = regv[3][POS_HP_MUTE] ? 5'h00 : regv[3][4:0];
      e.headphone_pulldown_select = regv[3][POS_HP_PULLDOWN];
      e.lineout_route_b = regv[4];
      e.pair_avg_route = regv[5][5:0];
      e.differential_enable = regv[6][POS_DIFF_EN];
      e.differential_to_headphone = regv[6][POS_DIFF_HP] & regv[6][0];
      e.differential_to_mono = regv[6][POS_DIFF_MONO] & regv[6][0];
      return e;
   endfunction : model

   // One bus access, held until waitrequest is seen low at an edge
   task automatic bus(input logic is_wr, input logic [4:0] idx,
      input logic [7:0] d, input logic [3:0] ben, input logic [31:0] exp);
      logic w;
      int n;
      w = 1'b1;
      n = 0;
      if (!is_wr)
         exp_q.push_back(exp);
      rd <= !is_wr;
      wr <= is_wr;
      addr <= {idx, 2'b00};
      wdata <= {24'($random(seed)), d};
      be <= ben;
      while (w !== 1'b0 && n < 20)
      begin
         @(negedge ref_clk_i);
         w = wait_req;
         @(posedge ref_clk_i);
         n++;
      end
      check("waitrequest", 64'(w), 64'h0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge ref_clk_i);
   endtask : bus

   // Register write with expected contents kept
   task automatic wreg(input int k, input logic [7:0] d);
      bus(1'b1, idx_tab[k], d & mask_tab[k], 4'h1, 32'h0);
      if (pd_n)
         regv[k] = d & mask_tab[k];
   endtask : wreg

   // Register read against expected contents
   task automatic rreg(input int k);
      bus(1'b0, idx_tab[k], 8'h00, 4'h1, {24'h000000, regv[k]});
   endtask : rreg

   // Settled look at the control bundle
   task automatic cctl;
      analog_ctrl_type s;
      @(negedge ref_clk_i);
      s = ctrl;
      s.lineout_route_a = '0;
      check("ctrl", 64'(s), 64'(model()));
      @(posedge ref_clk_i);
   endtask : cctl

   // Read results taken at the falling edge of the answer cycle
   always @(negedge ref_clk_i)
   begin
      if (rd && wait_req === 1'b0)
         check("readdata", 64'(rdata), 64'(exp_q.pop_front()));
   end

   // Watchdog
   initial
   begin
      #400000;
      miscompares++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      defaults();
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      for (int k = 0; k < 8; k++)
         rreg(k);
      cctl();
      // Random writes, read back and control update
      for (int i = 0; i < 120; i++)
      begin
         wreg(i < 8 ? i : {$random(seed)} % 8, 8'($random(seed)));
         cctl();
         rreg({$random(seed)} % 8);
      end
      // Unmapped place and disabled byte lane are both ignored
      bus(1'b1, 5'h0a, 8'h5a, 4'h1, 32'h0);
      bus(1'b0, 5'h0a, 8'h00, 4'h1, READ_UNMAPPED);
      bus(1'b1, idx_tab[4], ~regv[4], 4'he, 32'h0);
      rreg(4);
      // Power-down pin forces defaults and blocks writes
      pd_n <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      defaults();
      wreg(2, 8'hff);
      rreg(2);
      cctl();
      pd_n <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      wreg(3, 8'h51);
      cctl();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
